// *** shared/aspr_pkg.sv ***
// Purpose: Constants and types for the selection/reselection status reporter
// Assumes: One clock domain; bus lines arrive unsynchronised
// Notes:   Codes and steps are the values presented to the host processor
package aspr_pkg;

    // Bit positions inside the synchronised bus-line vector
    localparam int BUS_W   = 8;
    localparam int BUS_BSY = 0;
    localparam int BUS_SEL = 1;
    localparam int BUS_RST = 2;
    localparam int BUS_ATN = 3;
    localparam int BUS_CD  = 4;
    localparam int BUS_IO  = 5;
    localparam int BUS_MSG = 6;
    localparam int BUS_REQ = 7;

    // Interrupt codes
    localparam logic [7:0] CODE_RESET      = 8'h01;
    localparam logic [7:0] CODE_FREE_MSGIN = 8'h31;
    localparam logic [7:0] CODE_PHASE_CHG  = 8'h32;
    localparam logic [7:0] CODE_DEFERRED   = 8'h64;
    localparam logic [7:0] CODE_EXT_LONG   = 8'h67;
    localparam logic [7:0] CODE_FREE_IDLE  = 8'h70;
    localparam logic [7:0] CODE_RESEL_MAN  = 8'h90;
    localparam logic [7:0] CODE_NOT_MSGIN  = 8'hB0;
    localparam logic [7:0] CODE_MSG_DONE   = 8'hB1;

    // Sequence steps
    localparam logic [7:0] STEP_00 = 8'h00;
    localparam logic [7:0] STEP_01 = 8'h01;
    localparam logic [7:0] STEP_02 = 8'h02;
    localparam logic [7:0] STEP_81 = 8'h81;
    localparam logic [7:0] STEP_82 = 8'h82;
    localparam logic [7:0] STEP_92 = 8'h92;
    localparam logic [7:0] STEP_93 = 8'h93;
    localparam logic [7:0] STEP_B1 = 8'hB1;

    // Message classification
    localparam logic [7:0] MSG_EXTENDED  = 8'h01;
    localparam logic [7:0] MSG_TWO_LO    = 8'h20;
    localparam logic [7:0] MSG_TWO_HI    = 8'h2F;
    localparam logic [7:0] EXT_LEN_LIMIT = 8'h21;
    localparam logic [8:0] MSG_LEN_ONE   = 9'h001;
    localparam logic [8:0] MSG_LEN_TWO   = 9'h002;
    localparam logic [8:0] EXT_HDR_LEN   = 9'h002;
    localparam int         IDENTIFY_BIT  = 7;

    // Pending report queue
    localparam int         QUEUE_DEPTH = 4;
    localparam logic [2:0] QUEUE_FULL  = 3'h4;

    typedef enum logic [3:0] {
        ST_IDLE         = 4'h0,
        ST_RESEL_WAIT   = 4'h1,
        ST_MSG_IN       = 4'h2,
        ST_SELECTING    = 4'h3,
        ST_SEL_MSGO     = 4'h4,
        ST_SEL_MSG2     = 4'h5,
        ST_SEL_CMD1     = 4'h6,
        ST_SEL_ATN_MSGO = 4'h7,
        ST_SEL_CMD      = 4'h8
    } aspr_state_type;

endpackage : aspr_pkg

// *** src/aspr_sync2.sv ***
// Purpose: Two-flop synchroniser for a group of asynchronous levels
// Assumes: Each bit is an independent level
// Notes:   Only the second stage leaves this module
`timescale 1ns/100ps
module aspr_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            meta_q <= '0;
            dout   <= '0;
        end
        else
        begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule : aspr_sync2

// *** src/aspr_status_report.sv ***
// Purpose: Interrupt code and sequence step reporting for automatic
//          selection and reselection response
// Assumes: Event strobes come from the transfer engine on the same clock
// Notes:   Reports wait in a small queue and are shown one at a time
`timescale 1ns/100ps
module aspr_status_report (
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       reset,
    // Bus lines, asynchronous
    input  wire logic [aspr_pkg::BUS_W-1:0] bus_lines,
    // Transfer engine events
    input  wire logic                       reselected,
    input  wire logic                       sel_start,
    input  wire logic                       selected,
    input  wire logic                       arb_lost,
    input  wire logic                       rx_valid,
    input  wire logic [7:0]                 rx_byte,
    input  wire logic                       cmd_block_done,
    input  wire logic                       host_cmd,
    // Configuration
    input  wire logic                       auto_resel_en,
    input  wire logic                       auto_sel_en,
    input  wire logic                       sel_to_cmd,
    // Host side
    output logic                            irq,
    output logic [7:0]                      irq_code,
    output logic [7:0]                      irq_step,
    input  wire logic                       irq_ack,
    output logic                            xfer_active
);
    import aspr_pkg::*;

    logic [BUS_W-1:0] bus_s;
    logic             req_prev_q;
    aspr_state_type   state_q, state_d;
    logic [8:0]       bcnt_q, bcnt_d;
    logic [8:0]       mlen_q, mlen_d;
    logic             xfer_any_q, xfer_any_d;
    logic             defer_q, defer_d;
    logic             pend_q, pend_d;
    logic             active_q, active_d;
    logic [7:0]       qc_q [QUEUE_DEPTH];
    logic [7:0]       qs_q [QUEUE_DEPTH];
    logic [7:0]       qc_d [QUEUE_DEPTH];
    logic [7:0]       qs_d [QUEUE_DEPTH];
    logic [2:0]       qcnt_q, qcnt_d;
    logic             push0, push1;
    logic [7:0]       code0, step0, code1, step1;
    logic             bus_free, bus_rst, req_edge, ph_msg_in, ext_long;
    logic [8:0]       bcnt_inc;

    // Bus lines come from pins, so pass two flops first
    aspr_sync2 #(
        .WIDTH (BUS_W)
    ) u_sync (
        .clock (clock),
        .reset (reset),
        .din   (bus_lines),
        .dout  (bus_s)
    );

    // Decoded bus conditions from the synchronised lines
    assign bus_free  = !bus_s[BUS_BSY] && !bus_s[BUS_SEL];
    assign bus_rst   = bus_s[BUS_RST];
    assign req_edge  = bus_s[BUS_REQ] && !req_prev_q;
    assign ph_msg_in = bus_s[BUS_MSG] && bus_s[BUS_CD] && bus_s[BUS_IO];
    assign bcnt_inc  = bcnt_q + 9'h001;
    assign ext_long  = (rx_byte == 8'h00) || (rx_byte >= EXT_LEN_LIMIT);

    // Outcome detection and sequencing
    always_comb
    begin
        state_d    = state_q;
        bcnt_d     = bcnt_q;
        mlen_d     = mlen_q;
        xfer_any_d = xfer_any_q;
        defer_d    = defer_q || arb_lost;
        pend_d     = pend_q;
        push0      = 1'b0;
        push1      = 1'b0;
        code0      = 8'h00;
        step0      = 8'h00;
        code1      = 8'h00;
        step1      = 8'h00;
        case (state_q)
            ST_IDLE:
            begin
                if (reselected)
                begin
                    bcnt_d     = 9'h000;
                    xfer_any_d = 1'b0;
                    if (defer_q)
                    begin
                        push0   = 1'b1;
                        code0   = CODE_DEFERRED;
                        step0   = STEP_00;
                        defer_d = arb_lost;
                    end
                    if (!auto_resel_en)
                    begin
                        push1 = 1'b1;
                        code1 = CODE_RESEL_MAN;
                        step1 = STEP_00;
                    end
                    else
                    begin
                        state_d = ST_RESEL_WAIT;
                    end
                end
                else if (sel_start && auto_sel_en)
                begin
                    state_d = ST_SELECTING;
                end
                else if (pend_q)
                begin
                    push0  = 1'b1;
                    code0  = CODE_DEFERRED;
                    step0  = STEP_00;
                    pend_d = 1'b0;
                end
            end
            ST_RESEL_WAIT:
            begin
                if (bus_rst)
                begin
                    push0   = 1'b1;
                    code0   = CODE_RESET;
                    step0   = STEP_00;
                    state_d = ST_IDLE;
                end
                else if (bus_free)
                begin
                    push0   = 1'b1;
                    code0   = CODE_FREE_IDLE;
                    step0   = STEP_00;
                    state_d = ST_IDLE;
                end
                else if (req_edge && ph_msg_in)
                begin
                    state_d = ST_MSG_IN;
                end
                else if (req_edge)
                begin
                    push0   = 1'b1;
                    code0   = CODE_NOT_MSGIN;
                    step0   = STEP_01;
                    state_d = ST_IDLE;
                end
            end
            ST_MSG_IN:
            begin
                // Abnormal endings return to idle at the next edge, so xfer_active drops one cycle after they are seen
                if (bus_rst)
                begin
                    push0   = 1'b1;
                    code0   = CODE_RESET;
                    step0   = STEP_01;
                    state_d = ST_IDLE;
                end
                else if (bus_free)
                begin
                    push0   = 1'b1;
                    code0   = CODE_FREE_MSGIN;
                    step0   = STEP_01;
                    state_d = ST_IDLE;
                end
                else if (req_edge && !ph_msg_in)
                begin
                    push0   = 1'b1;
                    code0   = CODE_PHASE_CHG;
                    step0   = STEP_01;
                    state_d = ST_IDLE;
                end
                else if (rx_valid)
                begin
                    bcnt_d = bcnt_inc;
                    if (bcnt_q == 9'h000)
                    begin
                        mlen_d = (rx_byte == MSG_EXTENDED) ? 9'h1FF :
                                 (rx_byte >= MSG_TWO_LO && rx_byte <= MSG_TWO_HI) ?
                                 MSG_LEN_TWO : MSG_LEN_ONE;
                    end
                    else if (bcnt_q == 9'h001 && mlen_q == 9'h1FF)
                    begin
                        mlen_d = {1'b0, rx_byte} + EXT_HDR_LEN;
                    end
                    if (bcnt_q == 9'h001 && mlen_q == 9'h1FF && ext_long)
                    begin
                        push0   = 1'b1;
                        code0   = CODE_EXT_LONG;
                        step0   = STEP_01;
                        push1   = 1'b1;
                        code1   = CODE_MSG_DONE;
                        step1   = STEP_02;
                        state_d = ST_IDLE;
                    end
                    else if ((bcnt_q == 9'h000 && rx_byte != MSG_EXTENDED &&
                              !(rx_byte >= MSG_TWO_LO && rx_byte <= MSG_TWO_HI)) ||
                             (bcnt_q != 9'h000 && bcnt_inc == mlen_d))
                    begin
                        push0   = 1'b1;
                        code0   = CODE_MSG_DONE;
                        step0   = STEP_02;
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_SELECTING:
            begin
                if (bus_rst)
                begin
                    push0   = 1'b1;
                    code0   = CODE_RESET;
                    step0   = STEP_00;
                    state_d = ST_IDLE;
                end
                else if (selected)
                begin
                    xfer_any_d = 1'b0;
                    state_d    = sel_to_cmd ? ST_SEL_CMD : ST_SEL_MSGO;
                end
            end
            default:
            begin
                // Target-side transfer states after selection
                if (bus_rst)
                begin
                    push0   = 1'b1;
                    code0   = CODE_RESET;
                    state_d = ST_IDLE;
                    case (state_q)
                        ST_SEL_MSGO:     step0 = STEP_81;
                        ST_SEL_MSG2:     step0 = STEP_82;
                        ST_SEL_CMD1:     step0 = STEP_92;
                        ST_SEL_ATN_MSGO: step0 = STEP_93;
                        default:         step0 = STEP_B1;
                    endcase
                end
                else if (bus_free)
                begin
                    push0   = !xfer_any_q;
                    code0   = CODE_FREE_IDLE;
                    step0   = STEP_00;
                    state_d = ST_IDLE;
                end
                else if (rx_valid || cmd_block_done)
                begin
                    xfer_any_d = 1'b1;
                    case (state_q)
                        ST_SEL_MSGO:
                            state_d = (rx_byte[IDENTIFY_BIT] && bus_s[BUS_ATN]) ?
                                      ST_SEL_MSG2 : ST_SEL_CMD1;
                        ST_SEL_MSG2:
                            state_d = ST_SEL_CMD1;
                        ST_SEL_CMD1:
                            state_d = bus_s[BUS_ATN] ? ST_SEL_ATN_MSGO : ST_IDLE;
                        default:
                            state_d = ST_IDLE;
                    endcase
                end
            end
        endcase
        // A host command during post-reselection work is answered afterwards
        if (host_cmd && state_q != ST_IDLE && state_q != ST_SELECTING)
        begin
            pend_d = 1'b1;
        end
        active_d = (state_d == ST_MSG_IN) || (state_d >= ST_SEL_MSGO);
    end

    // Report queue: head is entry zero, so code and step outputs come straight from flops
    always_comb
    begin
        qc_d   = qc_q;
        qs_d   = qs_q;
        qcnt_d = qcnt_q;
        if (irq_ack && qcnt_q != 3'h0)
        begin
            for (int i = 0; i < QUEUE_DEPTH - 1; i++)
            begin
                qc_d[i] = qc_q[i+1];
                qs_d[i] = qs_q[i+1];
            end
            qc_d[QUEUE_DEPTH-1] = 8'h00;
            qs_d[QUEUE_DEPTH-1] = 8'h00;
            qcnt_d              = qcnt_q - 3'h1;
        end
        if (push0 && qcnt_d != QUEUE_FULL)
        begin
            qc_d[qcnt_d[1:0]] = code0;
            qs_d[qcnt_d[1:0]] = step0;
            qcnt_d            = qcnt_d + 3'h1;
        end
        if (push1 && qcnt_d != QUEUE_FULL)
        begin
            qc_d[qcnt_d[1:0]] = code1;
            qs_d[qcnt_d[1:0]] = step1;
            qcnt_d            = qcnt_d + 3'h1;
        end
    end

    // State registers
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_q    <= ST_IDLE;
            bcnt_q     <= 9'h000;
            mlen_q     <= 9'h000;
            xfer_any_q <= 1'b0;
            defer_q    <= 1'b0;
            pend_q     <= 1'b0;
            active_q   <= 1'b0;
            req_prev_q <= 1'b0;
            qcnt_q     <= 3'h0;
            for (int i = 0; i < QUEUE_DEPTH; i++)
            begin
                qc_q[i] <= 8'h00;
                qs_q[i] <= 8'h00;
            end
        end
        else
        begin
            state_q    <= state_d;
            bcnt_q     <= bcnt_d;
            mlen_q     <= mlen_d;
            xfer_any_q <= xfer_any_d;
            defer_q    <= defer_d;
            pend_q     <= pend_d;
            active_q   <= active_d;
            req_prev_q <= bus_s[BUS_REQ];
            qcnt_q     <= qcnt_d;
            qc_q       <= qc_d;
            qs_q       <= qs_d;
        end
    end

    assign irq         = (qcnt_q != 3'h0);
    assign irq_code    = qc_q[0];
    assign irq_step    = qs_q[0];
    assign xfer_active = active_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_empty_idle;
        qcnt_q == 3'h0 && !irq_ack;
    endsequence

    sequence s_ext_long;
        state_q == ST_MSG_IN && !bus_rst && !bus_free && !req_edge && rx_valid &&
        bcnt_q == 9'h001 && mlen_q == 9'h1FF && ext_long;
    endsequence

    chk_free_msgin: assert property (
        s_empty_idle ##0 (state_q == ST_MSG_IN && !bus_rst && bus_free)
        |=> irq && irq_code == 8'h31 && irq_step == 8'h01)
        else $error("bus free in message-in not reported as 31/01");

    chk_free_stop: assert property (
        state_q == ST_MSG_IN && (bus_free || (req_edge && !ph_msg_in)) |=> !xfer_active)
        else $error("transfer still active after abnormal end");

    chk_phase_chg: assert property (
        s_empty_idle ##0 (state_q == ST_MSG_IN && !bus_rst && !bus_free && req_edge
        && !ph_msg_in) |=> irq_code == 8'h32 && irq_step == 8'h01)
        else $error("phase change not reported as 32/01");

    chk_ext_order: assert property (
        s_empty_idle ##0 s_ext_long |=> irq_code == 8'h67 && irq_step == 8'h01 &&
        qcnt_q == 3'h2 && qc_q[1] == 8'hB1 && qs_q[1] == 8'h02)
        else $error("oversize extended message not reported as 67 then B1");

    chk_deferred_first: assert property (
        s_empty_idle ##0 (state_q == ST_IDLE && reselected && defer_q)
        |=> irq_code == 8'h64 && irq_step == 8'h00)
        else $error("deferred reselection not reported first");

    chk_manual_resel: assert property (
        s_empty_idle ##0 (state_q == ST_IDLE && reselected && !defer_q && !auto_resel_en)
        |=> irq_code == 8'h90 && irq_step == 8'h00 && state_q == ST_IDLE)
        else $error("manual reselection not reported as 90/00");

    chk_not_msgin: assert property (
        s_empty_idle ##0 (state_q == ST_RESEL_WAIT && !bus_rst && !bus_free && req_edge
        && !ph_msg_in) |=> irq_code == 8'hB0 && irq_step == 8'h01)
        else $error("non message-in phase not reported as B0/01");

    chk_msgo_reset: assert property (
        s_empty_idle ##0 (state_q == ST_SEL_MSGO && bus_rst)
        |=> irq_code == 8'h01 && irq_step == 8'h81)
        else $error("reset in message-out not reported as 01/81");

    chk_cmd_reset: assert property (
        s_empty_idle ##0 (state_q == ST_SEL_CMD && bus_rst)
        |=> irq_code == 8'h01 && irq_step == 8'hB1)
        else $error("reset in command phase not reported as 01/B1");

    chk_head_hold: assert property (
        irq && !irq_ack |=> irq && $stable(irq_code) && $stable(irq_step))
        else $error("pending report changed before acknowledge");

endmodule : aspr_status_report

// *** bench/aspr_far_end.sv ***
// Purpose: Far-end SCSI device that sets the bus phase seen by the reporter
// Assumes: The bench picks the phase; lines are active high
// Notes:   Released lines read 0, as terminated lines do when idle
`timescale 1ns/100ps
module aspr_far_end (
    // Phase choice from the bench
    input  wire logic [2:0]                 mode,
    // Bus levels seen by the device
    output logic      [aspr_pkg::BUS_W-1:0] bus_lines
);
    import aspr_pkg::*;

    // Phase table; REQ is high in transfer phases, the bench drops it between them
    always_comb
    begin
        case (mode)
            3'h1:    bus_lines = 8'h01; // Busy, no request
            3'h2:    bus_lines = 8'hF1; // Message in
            3'h3:    bus_lines = 8'hA1; // Data in
            3'h4:    bus_lines = 8'h04; // Bus reset
            3'h5:    bus_lines = 8'h23; // Selection
            3'h6:    bus_lines = 8'h09; // Busy with attention
            default: bus_lines = 8'h00; // Bus free
        endcase
    end
endmodule : aspr_far_end

// *** bench/aspr_status_report_tb.sv ***
// Purpose: Self-checking bench for the status reporter
// Assumes: Reports are read and acknowledged one at a time
// Notes:   Each scenario starts from a fresh reset
`timescale 1ns/100ps
module aspr_status_report_tb;
    import aspr_pkg::*;
    localparam int RESEL = 0, SSTART = 1, SELD = 2, ARB = 3, RX = 4, CMD = 5, HOST = 6;
    logic       clock, reset, irq, irq_ack, xfer_active, auto_resel_en, auto_sel_en, sel_to_cmd;
    logic [7:0] irq_code, irq_step, rx_byte, bus_lines;
    logic [6:0] ev;
    logic [2:0] mode;
    int         errors, tests_run, cycles;

    // Design and far end
    aspr_far_end far (.mode(mode), .bus_lines(bus_lines));
    aspr_status_report dut (.clock(clock), .reset(reset), .bus_lines(bus_lines),
        .reselected(ev[RESEL]), .sel_start(ev[SSTART]), .selected(ev[SELD]),
        .arb_lost(ev[ARB]), .rx_valid(ev[RX]), .rx_byte(rx_byte),
        .cmd_block_done(ev[CMD]), .host_cmd(ev[HOST]), .auto_resel_en(auto_resel_en),
        .auto_sel_en(auto_sel_en), .sel_to_cmd(sel_to_cmd), .irq(irq), .irq_code(irq_code),
        .irq_step(irq_step), .irq_ack(irq_ack), .xfer_active(xfer_active));

    // Clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Hang guard; every scenario is at most a few hundred cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    task automatic check(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : check

    task automatic rst();
        @(posedge clock) reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        mode <= 3'h0;
        repeat (2) @(posedge clock);
    endtask : rst

    // One-cycle strobe on an engine event
    task automatic pulse(input int i);
        @(posedge clock) ev[i] <= 1'b1;
        @(posedge clock) ev[i] <= 1'b0;
    endtask : pulse

    task automatic rx(input logic [7:0] b);
        @(posedge clock)
        begin
            rx_byte <= b;
            ev[RX] <= 1'b1;
        end
        @(posedge clock) ev[RX] <= 1'b0;
    endtask : rx

    // A phase without REQ first, so every new transfer phase gives one REQ rising edge;
    // extra edges cover the two-flop bus synchroniser
    task automatic phase(input logic [2:0] m);
        @(posedge clock) mode <= 3'h1;
        @(posedge clock) mode <= m;
        repeat (3) @(posedge clock);
    endtask : phase

    // Wait for the head report, compare it, then pop it
    task automatic expect_irq(input logic [7:0] c, input logic [7:0] s);
        int n;
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
        end while (irq !== 1'b1 && n < 40);
        check(irq_code === c && irq_step === s, "wrong code or step");
        @(posedge clock) irq_ack <= 1'b1;
        @(posedge clock) irq_ack <= 1'b0;
    endtask : expect_irq

    task automatic msgin();
        int n;
        phase(3'h1);
        pulse(RESEL);
        phase(3'h2);
        n = 0;
        while (xfer_active !== 1'b1 && n < 20)
        begin
            @(negedge clock);
            n++;
        end
        check(xfer_active === 1'b1, "message-in not entered");
    endtask : msgin

    // Target side: depth 1 single command, 2 identify with ATN, 3 ATN after command
    task automatic tgt(input logic s2c, input int depth, input logic [7:0] st);
        rst();
        sel_to_cmd <= s2c;
        phase(3'h5);
        pulse(SSTART);
        pulse(SELD);
        phase(depth == 2 ? 3'h6 : 3'h1);
        if (depth > 0)
            rx(8'h80);
        if (depth == 3)
        begin
            phase(3'h6);
            pulse(CMD);
        end
        phase(3'h4);
        expect_irq(CODE_RESET, st);
    endtask : tgt

    task automatic t_resel();
        rst();
        msgin();
        rx(8'h00);
        expect_irq(8'hB1, 8'h02);
        @(negedge clock);
        check(irq === 1'b0 && xfer_active === 1'b0, "queue not empty");
        msgin();
        phase(3'h0);
        expect_irq(8'h31, 8'h01);
        check(xfer_active === 1'b0, "transfer still running");
        msgin();
        phase(3'h3);
        expect_irq(8'h32, 8'h01);
        check(xfer_active === 1'b0, "transfer still running");
        phase(3'h1);
        pulse(RESEL);
        phase(3'h3);
        expect_irq(8'hB0, 8'h01);
    endtask : t_resel

    task automatic t_manual();
        rst();
        auto_resel_en <= 1'b0;
        phase(3'h1);
        pulse(RESEL);
        expect_irq(8'h90, 8'h00);
        auto_resel_en <= 1'b1;
        // Bus reset while waiting after reselection, then during message-in
        pulse(RESEL);
        phase(3'h4);
        expect_irq(8'h01, 8'h00);
        msgin();
        phase(3'h4);
        expect_irq(8'h01, 8'h01);
    endtask : t_manual

    task automatic t_ext();
        rst();
        msgin();
        rx(8'h01);
        rx(8'h21);
        expect_irq(8'h67, 8'h01);
        check(xfer_active === 1'b0, "kept receiving past byte two");
        expect_irq(8'hB1, 8'h02);
    endtask : t_ext

    task automatic t_order();
        rst();
        phase(3'h1);
        pulse(ARB);
        pulse(RESEL);
        expect_irq(8'h64, 8'h00);
        phase(3'h2);
        rx(8'h00);
        expect_irq(8'hB1, 8'h02);
        msgin();
        pulse(HOST);
        rx(8'h00);
        expect_irq(8'hB1, 8'h02);
        expect_irq(8'h64, 8'h00);
    endtask : t_order

    task automatic t_sel();
        // Selection response switched off: a bus reset is not answered
        rst();
        auto_sel_en <= 1'b0;
        phase(3'h5);
        pulse(SSTART);
        phase(3'h4);
        @(negedge clock);
        check(irq === 1'b0, "selection answered while disabled");
        auto_sel_en <= 1'b1;
        rst();
        phase(3'h5);
        pulse(SSTART);
        phase(3'h4);
        expect_irq(8'h01, 8'h00);
        rst();
        phase(3'h5);
        pulse(SSTART);
        pulse(SELD);
        phase(3'h0);
        expect_irq(8'h70, 8'h00);
        tgt(1'b0, 0, 8'h81);
        tgt(1'b1, 0, 8'hB1);
        tgt(1'b0, 2, 8'h82);
        tgt(1'b0, 1, 8'h92);
        tgt(1'b0, 3, 8'h93);
    endtask : t_sel

    // Main sequence
    initial
    begin
        errors = 0;
        tests_run = 0;
        cycles = 0;
        reset = 1'b1;
        ev = '0;
        rx_byte = 8'h00;
        mode = 3'h0;
        irq_ack = 1'b0;
        auto_resel_en = 1'b1;
        auto_sel_en = 1'b1;
        sel_to_cmd = 1'b0;
        t_resel();
        t_manual();
        t_ext();
        t_order();
        t_sel();
        finish_test();
    end
endmodule : aspr_status_report_tb
